// ==== design/fac_pkg.sv ====
package fac_pkg;
    // ****************************************************************
    // Sizes and register map
    // ****************************************************************
    localparam int NFILE = 4;
    localparam int FBYTES = 32;
    localparam int NBUF = 32;
    localparam logic [7:0] A_CMD = 8'h00;
    localparam logic [7:0] A_GO = 8'h04;
    localparam logic [7:0] A_STAT = 8'h08;
    localparam logic [7:0] A_CUR = 8'h0C;
    localparam logic [3:0] A_CFG_HI = 4'h1;
    localparam logic [31:0] REG_RST = 32'h0000_0000;
    localparam int GO_BIT = 0;
    localparam int ST_BUSY = 0;
    localparam int ST_DONE = 1;
    localparam int ST_ERR = 4;
    localparam int ST_PTR = 8;
    localparam int ST_CNT = 16;
    // ****************************************************************
    // Field codings
    // ****************************************************************
    localparam logic [1:0] FT_TRANS = 2'h0;
    localparam logic [1:0] FT_LIN = 2'h1;
    localparam logic [1:0] FT_CYC = 2'h2;
    localparam logic [2:0] M_NEXT = 3'h2;
    localparam logic [2:0] M_PREV = 3'h3;
    localparam logic [1:0] M_ABS = 2'h2;
    localparam logic [4:0] SID_RFU = 5'h1F;
    localparam logic [2:0] E_NONE = 3'h0;
    localparam logic [2:0] E_MODE = 3'h1;
    localparam logic [2:0] E_NOFILE = 3'h2;
    localparam logic [2:0] E_TYPE = 3'h3;
    localparam logic [2:0] E_ACCESS = 3'h4;
    localparam logic [2:0] E_RANGE = 3'h5;
    localparam logic [2:0] E_NODATA = 3'h6;
    // ****************************************************************
    // Types
    // ****************************************************************
    typedef enum logic [1:0] {OP_RDBIN, OP_UPBIN, OP_RDREC, OP_UPREC}
        fac_op_t;
    typedef struct packed {
        logic [7:0] len;
        logic [7:0] p2;
        logic [7:0] p1;
        logic [5:0] pad;
        fac_op_t op;
    } fac_cmd_t;
    typedef struct packed {
        logic [10:0] pad;
        logic [4:0] short_file_id;
        logic [3:0] cnt;
        logic [3:0] rlen;
        logic [2:0] pad2;
        logic exists;
        logic upd_ok;
        logic rd_ok;
        logic [1:0] ftype;
    } fac_cfg_t;
endpackage

// ==== design/fac_core.sv ====
`timescale 1ns/1ns
module fac_core
    import fac_pkg::*;
(
    // Clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // APB slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic pready,
    output logic [31:0] prdata,
    output logic pslverr
);
    typedef enum logic [1:0] {S_IDLE, S_DECODE, S_MOVE, S_FIN} fac_state_t;

    fac_state_t st_reg;
    fac_cmd_t cmd_reg;
    fac_cfg_t [NFILE-1:0] cfg_reg;
    logic [NFILE-1:0][3:0] ptr_reg;
    logic [NFILE-1:0][3:0] head_reg;
    logic [7:0] buf_mem [NBUF];
    logic [7:0] store_mem [NFILE*FBYTES];
    logic [1:0] cur_reg, tgt_reg;
    logic [4:0] off_reg, idx_reg;
    logic [5:0] cnt_reg, moved_reg;
    logic [2:0] err_reg;
    logic done_reg, set_ptr_reg, set_head_reg, set_cur_reg;
    logic [3:0] nptr_reg, nhead_reg;
    logic [31:0] prdata_reg;
    logic slverr_reg;

    // Decode results
    logic is_bin, is_upd, use_sid, cyc, nodata, bigrec, bad_mode;
    logic set_ptr, set_head;
    logic [2:0] mode, dec_err;
    logic [4:0] sid_w, sum, phys;
    logic [1:0] fsel, hit_idx;
    fac_cfg_t fc;
    logic [3:0] ptr_c, head_c, rec_w, nptr, nhead;
    logic [7:0] prod;
    logic [16:0] off16, span;
    logic [5:0] num_w;
    logic [NFILE-1:0] hit;

    // APB decode
    logic setup, wr, busy, is_cfg, is_buf, mapped;
    logic [1:0] cfg_i;
    logic [4:0] buf_i;

    // ****************************************************************
    // APB slave
    // ****************************************************************
    // Zero wait states: read data is captured in the setup cycle
    assign pready = 1'b1;
    assign prdata = prdata_reg;
    assign pslverr = slverr_reg;
    assign setup = psel && !penable;
    assign wr = psel && penable && pwrite;
    assign busy = st_reg != S_IDLE;
    assign is_cfg = paddr[7:4] == A_CFG_HI && paddr[1:0] == 2'h0;
    assign is_buf = paddr[7] && paddr[1:0] == 2'h0;
    assign cfg_i = paddr[3:2];
    assign buf_i = paddr[6:2];
    assign mapped = paddr == A_CMD || paddr == A_GO || paddr == A_STAT
        || paddr == A_CUR || is_cfg || is_buf;

    // Read mux and error answer, registered at setup
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            prdata_reg <= REG_RST;
            slverr_reg <= 1'b0;
        end
        else if (setup)
        begin
            slverr_reg <= !mapped;
            prdata_reg <= REG_RST;
            if (paddr == A_CMD)
                prdata_reg <= cmd_reg;
            else if (paddr == A_STAT)
            begin
                prdata_reg[ST_BUSY] <= busy;
                prdata_reg[ST_DONE] <= done_reg;
                prdata_reg[ST_ERR +: 3] <= err_reg;
                prdata_reg[ST_PTR +: 4] <= ptr_reg[cur_reg];
                prdata_reg[ST_CNT +: 6] <= moved_reg;
            end
            else if (paddr == A_CUR)
                prdata_reg[1:0] <= cur_reg;
            else if (is_cfg)
                prdata_reg <= cfg_reg[cfg_i];
            else if (is_buf)
                prdata_reg[7:0] <= buf_mem[buf_i];
        end
    end

    // Command and file setup; writes while busy are dropped
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            cmd_reg <= REG_RST;
            cfg_reg <= '0;
        end
        else if (wr && !busy)
        begin
            if (paddr == A_CMD)
                cmd_reg <= {pwdata[31:8], 6'h00, pwdata[1:0]};
            if (is_cfg)
                cfg_reg[cfg_i] <= {11'h000, pwdata[20:8], 3'h0,
                    pwdata[4:0]};
        end
    end

    // ****************************************************************
    // Command decode
    // ****************************************************************
    // Short identifier match, one comparator per file
    generate
        for (genvar gi = 0; gi < NFILE; gi++)
        begin : g_hit
            assign hit[gi] = cfg_reg[gi].exists
                && cfg_reg[gi].short_file_id == sid_w;
        end
    endgenerate

    // Lowest matching file wins
    always_comb
    begin
        hit_idx = 2'h0;
        for (int i = NFILE - 1; i >= 0; i--)
            if (hit[i])
                hit_idx = 2'(i);
    end

    // Target file, record number, offset and error, from cmd_reg, cur_reg and the selected file's setup, pointer and head
    always_comb
    begin
        is_bin = !cmd_reg.op[1];
        is_upd = cmd_reg.op[0];
        mode = cmd_reg.p2[2:0];
        // Binary: P1 b8 flags short id; record: P2 b8-b4
        use_sid = is_bin ? cmd_reg.p1[7] : cmd_reg.p2[7:3] != 5'h00;
        sid_w = is_bin ? cmd_reg.p1[4:0] : cmd_reg.p2[7:3];
        fsel = use_sid ? hit_idx : cur_reg;
        fc = cfg_reg[fsel];
        ptr_c = ptr_reg[fsel];
        head_c = head_reg[fsel];
        cyc = fc.ftype == FT_CYC;
        rec_w = 4'h0;
        set_ptr = 1'b0;
        set_head = 1'b0;
        nodata = 1'b0;
        bigrec = 1'b0;
        // P1 is not looked at in next or previous mode
        if (mode == M_NEXT)
        begin
            set_ptr = 1'b1;
            if (ptr_c == 4'h0)
                rec_w = 4'h1;
            else if (ptr_c >= fc.cnt)
            begin
                if (cyc)
                    rec_w = 4'h1;
                else
                    nodata = 1'b1;
            end
            else
                rec_w = ptr_c + 4'h1;
        end
        else if (mode == M_PREV)
        begin
            set_ptr = 1'b1;
            if (is_upd && cyc)
            begin
                // Oldest data sits in the last logical record
                rec_w = fc.cnt;
                set_head = 1'b1;
            end
            else if (ptr_c == 4'h0)
                rec_w = fc.cnt;
            else if (ptr_c == 4'h1)
            begin
                if (cyc)
                    rec_w = fc.cnt;
                else
                    nodata = 1'b1;
            end
            else
                rec_w = ptr_c - 4'h1;
        end
        else
        begin
            // P1 zero means current record
            rec_w = cmd_reg.p1 == 8'h00 ? ptr_c : cmd_reg.p1[3:0];
            bigrec = cmd_reg.p1[7:4] != 4'h0;
        end
        nptr = set_head ? 4'h1 : rec_w;
        // Logical record to physical slot around the cyclic head
        sum = {1'b0, head_c} + {1'b0, rec_w} - 5'h01;
        phys = sum >= {1'b0, fc.cnt} ? sum - {1'b0, fc.cnt} : sum;
        nhead = phys[3:0];
        prod = {4'h0, phys[3:0]} * {4'h0, fc.rlen};
        if (is_bin)
        begin
            off16 = use_sid ? {9'h000, cmd_reg.p2}
                : {2'h0, cmd_reg.p1[6:0], cmd_reg.p2};
            num_w = cmd_reg.len[5:0];
            span = off16 + {9'h000, cmd_reg.len};
        end
        else
        begin
            off16 = {9'h000, prod};
            num_w = {2'h0, fc.rlen};
            span = off16 + {13'h0000, fc.rlen};
        end
        // Reserved codes in either parameter byte
        bad_mode = is_bin ? cmd_reg.p1[7] && cmd_reg.p1[6:5] != 2'h0
            : sid_w == SID_RFU || !(mode == M_NEXT || mode == M_PREV
            || mode[2:1] == M_ABS);
        // First failing check names the error
        if (bad_mode)
            dec_err = E_MODE;
        else if (use_sid ? !(|hit) : !fc.exists)
            dec_err = E_NOFILE;
        else if (is_bin ? fc.ftype != FT_TRANS : !(cyc || fc.ftype == FT_LIN))
            dec_err = E_TYPE;
        else if (is_upd ? !fc.upd_ok : !fc.rd_ok)
            dec_err = E_ACCESS;
        else if (!is_bin && is_upd && cyc && mode != M_PREV)
            dec_err = E_MODE;
        else if (nodata)
            dec_err = E_NODATA;
        else if (!is_bin && (rec_w == 4'h0 || rec_w > fc.cnt || bigrec))
            dec_err = E_RANGE;
        else if (span > 17'(FBYTES))
            dec_err = E_RANGE;
        else if (!is_bin && is_upd && cmd_reg.len != {4'h0, fc.rlen})
            dec_err = E_RANGE;
        else
            dec_err = E_NONE;
    end

    // ****************************************************************
    // Sequencer
    // ****************************************************************
    // One byte per cycle between staging buffer and file store
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            st_reg <= S_IDLE;
            done_reg <= 1'b0;
            err_reg <= E_NONE;
            tgt_reg <= 2'h0;
            off_reg <= 5'h00;
            idx_reg <= 5'h00;
            cnt_reg <= 6'h00;
            moved_reg <= 6'h00;
            nptr_reg <= 4'h0;
            nhead_reg <= 4'h0;
            set_ptr_reg <= 1'b0;
            set_head_reg <= 1'b0;
            set_cur_reg <= 1'b0;
        end
        else
        begin
            case (st_reg)
                S_IDLE:
                    if (wr && paddr == A_GO && pwdata[GO_BIT])
                    begin
                        st_reg <= S_DECODE;
                        done_reg <= 1'b0;
                    end
                S_DECODE:
                begin
                    tgt_reg <= fsel;
                    off_reg <= off16[4:0];
                    cnt_reg <= num_w;
                    idx_reg <= 5'h00;
                    moved_reg <= 6'h00;
                    err_reg <= dec_err;
                    nptr_reg <= nptr;
                    nhead_reg <= nhead;
                    set_ptr_reg <= set_ptr && !is_bin;
                    set_head_reg <= set_head && !is_bin;
                    set_cur_reg <= use_sid;
                    // Errors skip the transfer entirely
                    st_reg <= dec_err == E_NONE ? S_MOVE : S_FIN;
                end
                S_MOVE:
                    if (cnt_reg == 6'h00)
                        st_reg <= S_FIN;
                    else
                    begin
                        cnt_reg <= cnt_reg - 6'h01;
                        off_reg <= off_reg + 5'h01;
                        idx_reg <= idx_reg + 5'h01;
                        moved_reg <= moved_reg + 6'h01;
                    end
                S_FIN:
                begin
                    done_reg <= 1'b1;
                    st_reg <= S_IDLE;
                end
                default:
                    st_reg <= S_IDLE;
            endcase
        end
    end

    // Pointer and head move only on success; current file on success or on an idle A_CUR write
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            ptr_reg <= '0;
            head_reg <= '0;
            cur_reg <= 2'h0;
        end
        else if (st_reg == S_FIN && err_reg == E_NONE)
        begin
            if (set_ptr_reg)
                ptr_reg[tgt_reg] <= nptr_reg;
            if (set_head_reg)
                head_reg[tgt_reg] <= nhead_reg;
            if (set_cur_reg)
                cur_reg <= tgt_reg;
        end
        else if (wr && !busy && paddr == A_CUR)
            cur_reg <= pwdata[1:0];
    end

    // Staging buffer: software fills it idle, reads land here
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            for (int i = 0; i < NBUF; i++)
                buf_mem[i] <= 8'h00;
        else if (st_reg == S_MOVE && cnt_reg != 6'h00 && !is_upd)
            buf_mem[idx_reg] <= store_mem[{tgt_reg, off_reg}];
        else if (wr && !busy && is_buf)
            buf_mem[buf_i] <= pwdata[7:0];
    end

    // File store, written only by update commands
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            for (int i = 0; i < NFILE * FBYTES; i++)
                store_mem[i] <= 8'h00;
        else if (st_reg == S_MOVE && cnt_reg != 6'h00 && is_upd)
            store_mem[{tgt_reg, off_reg}] <= buf_mem[idx_reg];
    end

    // ****************************************************************
    // Checks
    // ****************************************************************
    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);

    sequence s_bin_ok;
        st_reg == S_DECODE && is_bin && dec_err == E_NONE;
    endsequence
    sequence s_move_len(logic [5:0] n);
        st_reg == S_MOVE && cnt_reg == n;
    endsequence

    rd_access_a: assert property (st_reg == S_DECODE && !is_upd
        && !fc.rd_ok |-> dec_err != E_NONE)
        else $error("read ran without read access");
    up_access_a: assert property (st_reg == S_DECODE && is_upd
        && !fc.upd_ok |-> dec_err != E_NONE)
        else $error("update ran without update access");
    bin_off_a: assert property (st_reg == S_DECODE && is_bin
        && !cmd_reg.p1[7] |-> off16 == {2'h0, cmd_reg.p1[6:0], cmd_reg.p2})
        else $error("binary offset wrong");
    sid_off_a: assert property (st_reg == S_DECODE && is_bin
        && cmd_reg.p1[7] |-> off16 == {9'h000, cmd_reg.p2})
        else $error("short id offset wrong");
    rd_count_a: assert property (s_bin_ok
        |=> s_move_len($past(cmd_reg.len[5:0])))
        else $error("byte count differs from length");
    upd_write_a: assert property (st_reg == S_MOVE && is_upd
        && cnt_reg != 6'h00 |=> store_mem[$past({tgt_reg, off_reg})]
        == $past(buf_mem[idx_reg]))
        else $error("update byte not stored");
    fail_ptr_a: assert property (st_reg == S_FIN
        && err_reg != E_NONE |=> $stable(ptr_reg) && $stable(head_reg))
        else $error("pointer moved on failure");
    abs_ptr_a: assert property (st_reg == S_DECODE && !is_bin
        && mode[2:1] == M_ABS |=> !set_ptr_reg)
        else $error("absolute mode moved pointer");
    next_wrap_a: assert property (st_reg == S_DECODE && !is_bin
        && mode == M_NEXT && cyc && ptr_c == fc.cnt && ptr_c != 4'h0
        |-> rec_w == 4'h1)
        else $error("cyclic next did not wrap");
    lin_end_a: assert property (st_reg == S_DECODE && !is_bin
        && mode == M_NEXT && fc.ftype == FT_LIN && ptr_c == fc.cnt
        && ptr_c != 4'h0 |-> dec_err != E_NONE)
        else $error("linear next past end");
    prev_wrap_a: assert property (st_reg == S_DECODE && !is_bin
        && !is_upd && mode == M_PREV && cyc && ptr_c == 4'h1
        |-> rec_w == fc.cnt)
        else $error("cyclic previous did not wrap");
    cyc_upd_a: assert property (st_reg == S_DECODE && !is_bin
        && is_upd && cyc && mode != M_PREV |-> dec_err != E_NONE)
        else $error("cyclic update outside previous");
    renum_a: assert property (st_reg == S_FIN && err_reg == E_NONE
        && set_head_reg |=> ptr_reg[$past(tgt_reg)] == 4'h1)
        else $error("cyclic update pointer not one");
endmodule

// ==== bench/fac_term.sv ====
`timescale 1ns/1ns
module fac_term
    import fac_pkg::*;
(
    // Clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // Bus master side
    output logic psel,
    output logic penable,
    output logic pwrite,
    output logic [7:0] paddr,
    output logic [31:0] pwdata,
    input wire logic pready,
    input wire logic [31:0] prdata,
    input wire logic pslverr
);
    // ****************************************************************
    // Bus cycles
    // ****************************************************************
    // Idle bus from time zero so no request leaks into reset
    initial
    begin
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 8'h00;
        pwdata = 32'h0000_0000;
    end

    // One transfer, held until pready is sampled high at an edge
    task automatic xfer(input logic wr, input logic [7:0] a,
        input logic [31:0] d, output logic [31:0] q, output logic err);
    begin
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        @(posedge pclk);
        while (pready !== 1'b1)
            @(posedge pclk);
        q = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        // Released data lines must not look like a held value
        pwdata <= ~d;
    end
    endtask

    // Issue a command, start it and poll until it is finished
    task automatic run(input fac_op_t op, input logic [7:0] p1,
        input logic [7:0] p2, input logic [7:0] len,
        output logic [31:0] st);
        logic [7:0] p1x;
        logic e;
    begin
        p1x = p1;
        // Record number goes out as zero in next/previous modes
        if (op inside {OP_RDREC, OP_UPREC} && p2[2:1] == 2'b01)
            p1x = 8'h00;
        xfer(1'b1, A_CMD, {len, p2, p1x, 6'h00, op}, st, e);
        xfer(1'b1, A_GO, 32'h0000_0001, st, e);
        st = 32'h0000_0001;
        while (st[ST_BUSY] !== 1'b0 || st[ST_DONE] !== 1'b1)
            xfer(1'b0, A_STAT, 32'h0000_0000, st, e);
    end
    endtask
endmodule

// ==== bench/file_access_commands_test.sv ====
`timescale 1ns/1ns
module file_access_commands_test
    import fac_pkg::*;
;
    // ****************************************************************
    // Signals and instances
    // ****************************************************************
    logic pclk;
    logic presetn;
    logic psel;
    logic penable;
    logic pwrite;
    logic [7:0] paddr;
    logic [31:0] pwdata;
    logic pready;
    logic [31:0] prdata;
    logic pslverr;
    logic [31:0] st;
    logic [31:0] q;
    logic e;
    int err_total;
    int n_tests;
    int cyc;

    fac_core i_dut (.pclk(pclk), .presetn(presetn), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .pready(pready), .prdata(prdata),
        .pslverr(pslverr));

    fac_term i_term (.pclk(pclk), .presetn(presetn), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .pready(pready), .prdata(prdata),
        .pslverr(pslverr));

    // ****************************************************************
    // Clock, timeout and helpers
    // ****************************************************************
    // 40 ns period
    initial
    begin
        pclk = 1'b0;
        forever #20 pclk = ~pclk;
    end

    // A hang counts as a mismatch; normal run is under a thousand cycles
    always @(posedge pclk)
    begin
        cyc++;
        if (cyc == 20000)
        begin
            err_total++;
            complete_run();
        end
    end

    task automatic complete_run();
    begin
        if (err_total == 0 && n_tests > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    end
    endtask

    task automatic chk(input string nm, input logic [31:0] seen, exp);
    begin
        n_tests++;
        if (seen !== exp)
        begin
            err_total++;
            $display("mismatch %s expected %h seen %h", nm, exp, seen);
        end
    end
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
    begin
        i_term.xfer(1'b1, a, d, q, e);
    end
    endtask

    task automatic rd(input logic [7:0] a);
    begin
        i_term.xfer(1'b0, a, 32'h0000_0000, q, e);
    end
    endtask

    // Buffer byte i lives at 0x80 + 4i
    task automatic ckb(input logic [4:0] i, input logic [7:0] v);
    begin
        rd({1'b1, i, 2'b00});
        chk("buffer", q, {24'h00_0000, v});
    end
    endtask

    // Code 7 is unused, so it stands for any nonzero error
    task automatic cmd(input fac_op_t op, input logic [7:0] p1, p2, len,
        input logic [2:0] xe, input logic [3:0] xp);
    begin
        i_term.run(op, p1, p2, len, st);
        if (xe == 3'h7)
            chk("error set", {31'h0, st[6:4] != 3'h0}, 32'h0000_0001);
        else
            chk("error", {29'h0, st[6:4]}, {29'h0, xe});
        chk("pointer", {28'h0, st[11:8]}, {28'h0, xp});
    end
    endtask

    // ****************************************************************
    // Main sequence
    // ****************************************************************
    initial
    begin
        presetn = 1'b0;
        err_total = 0;
        n_tests = 0;
        cyc = 0;
        repeat (4) @(posedge pclk);
        presetn <= 1'b1;
        rd(A_CMD);
        chk("cmd reset", q, REG_RST);
        chk("slave error", {31'h0, e}, 32'h0000_0000);
        chk("ready", {31'h0, pready}, 32'h0000_0001);
        rd(8'h40);
        chk("unmapped", {31'h0, e}, 32'h0000_0001);
        // Transparent file 0, short id 5, all rights
        wr(8'h10, 32'h0005_001C);
        wr(A_CUR, 32'h0000_0000);
        for (int i = 0; i < 4; i++)
            wr(8'h80 + 8'(4 * i), 32'h0000_00A0 + 32'(i));
        cmd(OP_UPBIN, 8'h00, 8'h04, 8'h04, E_NONE, 4'h0);
        for (int i = 0; i < 4; i++)
            wr(8'h80 + 8'(4 * i), 32'h0000_0000);
        cmd(OP_RDBIN, 8'h00, 8'h04, 8'h04, E_NONE, 4'h0);
        chk("count", {26'h0, st[21:16]}, 32'h0000_0004);
        for (int i = 0; i < 4; i++)
            ckb(5'(i), 8'hA0 + 8'(i));
        cmd(OP_RDBIN, 8'h01, 8'h04, 8'h01, E_RANGE, 4'h0);
        cmd(OP_RDBIN, 8'h85, 8'h05, 8'h02, E_NONE, 4'h0);
        ckb(5'h00, 8'hA1);
        ckb(5'h01, 8'hA2);
        cmd(OP_RDBIN, 8'hA5, 8'h05, 8'h01, E_MODE, 4'h0);
        // Update right withdrawn: contents must survive
        wr(8'h10, 32'h0005_0014);
        wr(8'h80, 32'h0000_0055);
        cmd(OP_UPBIN, 8'h00, 8'h04, 8'h01, E_ACCESS, 4'h0);
        cmd(OP_RDBIN, 8'h00, 8'h04, 8'h01, E_NONE, 4'h0);
        ckb(5'h00, 8'hA0);
        wr(8'h10, 32'h0005_0018);
        cmd(OP_RDBIN, 8'h00, 8'h04, 8'h01, E_ACCESS, 4'h0);
        // Linear files 1 and 3: two-byte records, three of them
        wr(8'h14, 32'h0006_321D);
        wr(8'h1C, 32'h0008_321D);
        wr(A_CUR, 32'h0000_0001);
        for (int r = 1; r <= 3; r++)
        begin
            wr(8'h80, 32'(r));
            cmd(OP_UPREC, 8'(r), 8'h04, 8'h02, E_NONE, 4'h0);
        end
        for (int r = 1; r <= 3; r++)
        begin
            cmd(OP_RDREC, 8'h00, 8'h02, 8'h00, E_NONE, 4'(r));
            ckb(5'h00, 8'(r));
        end
        cmd(OP_RDREC, 8'h00, 8'h02, 8'h00, E_NODATA, 4'h3);
        cmd(OP_RDREC, 8'h00, 8'h03, 8'h00, E_NONE, 4'h2);
        ckb(5'h00, 8'h02);
        cmd(OP_RDREC, 8'h03, 8'h04, 8'h00, E_NONE, 4'h2);
        ckb(5'h00, 8'h03);
        cmd(OP_RDREC, 8'h00, 8'h04, 8'h00, E_NONE, 4'h2);
        ckb(5'h00, 8'h02);
        cmd(OP_RDREC, 8'h00, 8'h01, 8'h00, E_MODE, 4'h2);
        cmd(OP_RDREC, 8'h01, 8'hFC, 8'h00, E_MODE, 4'h2);
        cmd(OP_RDREC, 8'h01, 8'h4C, 8'h00, E_NOFILE, 4'h2);
        cmd(OP_RDREC, 8'h04, 8'h04, 8'h00, E_RANGE, 4'h2);
        wr(8'h80, 32'h0000_0077);
        cmd(OP_UPREC, 8'h00, 8'h02, 8'h02, E_NONE, 4'h3);
        cmd(OP_RDREC, 8'h02, 8'h04, 8'h00, E_NONE, 4'h3);
        cmd(OP_RDREC, 8'h03, 8'h04, 8'h00, E_NONE, 4'h3);
        ckb(5'h00, 8'h77);
        cmd(OP_UPREC, 8'h00, 8'h02, 8'h02, E_NODATA, 4'h3);
        cmd(OP_UPREC, 8'h00, 8'h03, 8'h02, E_NONE, 4'h2);
        cmd(OP_RDREC, 8'h00, 8'h03, 8'h00, E_NONE, 4'h1);
        cmd(OP_UPREC, 8'h00, 8'h03, 8'h02, E_NODATA, 4'h1);
        cmd(OP_RDREC, 8'h00, 8'h03, 8'h00, E_NODATA, 4'h1);
        cmd(OP_UPREC, 8'h01, 8'h04, 8'h01, E_RANGE, 4'h1);
        cmd(OP_RDBIN, 8'h00, 8'h00, 8'h01, E_TYPE, 4'h1);
        wr(8'h14, 32'h0006_3219);
        cmd(OP_RDREC, 8'h00, 8'h02, 8'h00, E_ACCESS, 4'h1);
        // Fresh pointer in file 3, picked by short id 8
        cmd(OP_RDREC, 8'h00, 8'h43, 8'h00, E_NONE, 4'h3);
        ckb(5'h00, 8'h00);
        // Cyclic file 2, one-byte records, short id 7
        wr(8'h18, 32'h0007_311E);
        for (int v = 1; v <= 3; v++)
        begin
            wr(8'h80, 32'(v * 17));
            cmd(OP_UPREC, 8'h00, 8'h3B, 8'h01, E_NONE, 4'h1);
        end
        for (int r = 1; r <= 3; r++)
        begin
            cmd(OP_RDREC, 8'(r), 8'h04, 8'h00, E_NONE, 4'h1);
            ckb(5'h00, 8'(68 - 17 * r));
        end
        cmd(OP_RDREC, 8'h00, 8'h03, 8'h00, E_NONE, 4'h3);
        ckb(5'h00, 8'h11);
        cmd(OP_RDREC, 8'h00, 8'h02, 8'h00, E_NONE, 4'h1);
        ckb(5'h00, 8'h33);
        cmd(OP_UPREC, 8'h01, 8'h04, 8'h01, 3'h7, 4'h1);
        cmd(OP_UPREC, 8'h00, 8'h02, 8'h01, 3'h7, 4'h1);
        complete_run();
    end
endmodule
